// ### rtl/idc_top.sv
`timescale 1ns/10ps
`include "idc_regs.svh"
// What this block does
// - Seven fixed domains plus the peripherals, each with its own gate.
// - Idle instruction copies control into status.
// - Status bits 0 to 6 each disable their own domain; bits 7 to 9 disable nothing.
// - Bit 0 of control idles the CPU.
// - DMA/host clock stops on mask and status.
// - DMA finishes its transfer, then idles.
// - Host port idles without waiting.
// - Peripheral stops on its mask and status.
// - Busy peripheral finishes activity, then idles.
// - Memory interface idles after DMA goes quiet.
// - No SDRAM refresh while memory interface idle.
// - Memory idle via control needs masters idle.
// - Mode two stops all but clock module.
// - Mode three powers PLL down, stops clocks.
// - Oscillator power-down and wake enables, EXTERNAL_INTERRUPT_ZERO bit 1.
// - Oscillator wakes on enabled NMI/external interrupt.
// - Wait 41032 cycles after oscillator wake.
module idc_top #(
  parameter int NUM_PERIPH = 14,
  parameter int NUM_EXT_INT = 4,
  parameter int STABLE_CYCLES = `IDC_OSC_STABLE_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic WB_ACK_OUT,
  output logic [31:0] WB_DAT_OUT,
  input wire logic IDLE_EXEC_IN,
  input wire logic DMA_BUSY_IN,
  input wire logic ICACHE_BUSY_IN,
  input wire logic [NUM_PERIPH-1:0] PERIPH_BUSY_IN,
  input wire logic [NUM_EXT_INT-1:0] CPU_INT_EN_IN,
  input wire logic NMI_IN,
  input wire logic [NUM_EXT_INT-1:0] EXT_INT_IN,
  output idc_pkg::idc_gate_type GATE_OUT,
  output logic [NUM_PERIPH-1:0] GATE_PERIPH_OUT,
  output idc_pkg::idc_pll_type PLL_OUT,
  output logic REFRESH_EN_OUT,
  output logic RESUME_OUT
);
  import idc_pkg::*;

  // Refuse widths that do not fit the 16-bit registers
  if (NUM_PERIPH < 1 || NUM_PERIPH > 16) begin : g_chk_p
    $error("idc_top: NUM_PERIPH must be 1 to 16");
  end
  if (NUM_EXT_INT < 1 || NUM_EXT_INT > 15) begin : g_chk_i
    $error("idc_top: NUM_EXT_INT must be 1 to 15");
  end

  // Low NUM_PERIPH bits, and NMI plus one bit per external line
  localparam logic [15:0] PMASK_BITS = 16'((32'h0000_0001 << NUM_PERIPH) - 32'h0000_0001);
  localparam logic [15:0] WAKE_BITS = 16'((32'h0000_0001 << (NUM_EXT_INT + 1)) - 32'h0000_0001);

  // Byte-lane merge of a 16-bit register with write data
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel, input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (sel[0]) begin
      v[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      v[15:8] = dat[15:8];
    end
    return v & msk;
  endfunction : lane_merge

  // Register bus state
  logic ack_q, ack_d; // Bus acknowledge
  logic [31:0] rdat_q, rdat_d; // Read data
  logic [15:0] ctrl_q, ctrl_d; // idle_control_reg
  logic [15:0] mpm_q, mpm_d; // master_port_idle_mask
  logic [15:0] pm_q, pm_d; // peripheral_idle_mask
  logic [15:0] pll_q, pll_d; // pll_control_status_reg
  logic [15:0] osc_wakeup_enable_reg_q, osc_wakeup_enable_reg_d; // osc_wakeup_enable_reg

  // Sequencing state
  idc_state_type state_q, state_d; // Controller state
  logic [15:0] stat_q, stat_d; // idle_status_reg
  logic resume_q, resume_d; // Program flow resumes
  logic tstart; // Starts the stabilisation wait
  logic tdone; // Stabilisation wait over

  // Gate state
  idc_gate_type gate_q, gate_d; // Domain disables
  logic [NUM_PERIPH-1:0] pgate_q, pgate_d; // Peripheral disables
  idc_pll_type pllo_q, pllo_d; // PLL and oscillator controls
  logic refr_q, refr_d; // Refresh allowed

  // Pin synchronisers for wake sources
  logic [NUM_EXT_INT:0] wk_meta_q; // First stage only
  logic [NUM_EXT_INT:0] wk_sync_q; // Usable wake levels

  logic acc; // New bus access
  logic [NUM_EXT_INT-1:0] ext_s; // Synced external interrupts
  logic nmi_s; // Synced NMI
  logic wake_any; // Ends an idle with oscillator running
  logic wake_osc; // Restarts a powered-down oscillator
  logic osc_down; // Oscillator currently powered down

  assign acc = WB_CYC_IN & WB_STB_IN & ~ack_q;
  assign nmi_s = wk_sync_q[0];
  assign ext_s = wk_sync_q[NUM_EXT_INT:1];
  assign osc_down = (state_q == IDC_IDLE) & stat_q[`IDC_CTRL_CLK] & pll_q[`IDC_PLL_OSCPD];
  assign wake_any = nmi_s | (|(ext_s & CPU_INT_EN_IN));
  // Needs both wake enable and, for external lines, interrupt enable
  assign wake_osc = (nmi_s & osc_wakeup_enable_reg_q[`IDC_WAKE_NMI])
                  | (|(ext_s & CPU_INT_EN_IN & osc_wakeup_enable_reg_q[NUM_EXT_INT:1]));

  // Two flip-flops on the asynchronous wake pins
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      wk_meta_q <= '0;
      wk_sync_q <= '0;
    end else begin
      wk_meta_q <= {EXT_INT_IN, NMI_IN};
      wk_sync_q <= wk_meta_q;
    end
  end

  // Bus decode, register writes and read mux
  always_comb begin
    ack_d = acc;
    rdat_d = rdat_q;
    ctrl_d = ctrl_q;
    mpm_d = mpm_q;
    pm_d = pm_q;
    pll_d = pll_q;
    osc_wakeup_enable_reg_d = osc_wakeup_enable_reg_q;
    if (acc) begin
      rdat_d = 32'h0000_0000;
      case (WB_ADR_IN)
        `IDC_OFS_CTRL: begin
          rdat_d = {16'h0000, ctrl_q};
          if (WB_WE_IN) begin
            ctrl_d = lane_merge(ctrl_q, WB_DAT_IN, WB_SEL_IN, `IDC_CTRL_MASK);
          end
        end
        `IDC_OFS_STATUS: begin
          rdat_d = {16'h0000, stat_q};
        end
        `IDC_OFS_MPMASK: begin
          rdat_d = {16'h0000, mpm_q};
          if (WB_WE_IN) begin
            mpm_d = lane_merge(mpm_q, WB_DAT_IN, WB_SEL_IN, `IDC_MPMASK_MASK);
          end
        end
        `IDC_OFS_PMASK: begin
          rdat_d = {16'h0000, pm_q};
          if (WB_WE_IN) begin
            pm_d = lane_merge(pm_q, WB_DAT_IN, WB_SEL_IN, PMASK_BITS);
          end
        end
        `IDC_OFS_PLL: begin
          rdat_d = {16'h0000, pll_q};
          if (WB_WE_IN) begin
            pll_d = lane_merge(pll_q, WB_DAT_IN, WB_SEL_IN, `IDC_PLL_MASK);
          end
        end
        `IDC_OFS_WAKE: begin
          rdat_d = {16'h0000, osc_wakeup_enable_reg_q};
          if (WB_WE_IN) begin
            osc_wakeup_enable_reg_d = lane_merge(osc_wakeup_enable_reg_q, WB_DAT_IN, WB_SEL_IN, WAKE_BITS);
          end
        end
        `IDC_OFS_GATES: begin
          rdat_d = {16'(pgate_q), 5'h00, state_q, refr_q, 1'b0, gate_q};
        end
        default: begin
          rdat_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register the bus state
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ctrl_q <= `IDC_RST_CTRL;
      mpm_q <= `IDC_RST_MPMASK;
      pm_q <= `IDC_RST_PMASK;
      pll_q <= `IDC_RST_PLL;
      osc_wakeup_enable_reg_q <= `IDC_RST_WAKE;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
      mpm_q <= mpm_d;
      pm_q <= pm_d;
      pll_q <= pll_d;
      osc_wakeup_enable_reg_q <= osc_wakeup_enable_reg_d;
    end
  end

  // Idle sequencing: latch on idle instruction, wake, stabilise
  always_comb begin
    state_d = state_q;
    stat_d = stat_q;
    resume_d = 1'b0;
    tstart = 1'b0;
    case (state_q)
      IDC_RUN, IDC_IDLE: begin
        if (IDLE_EXEC_IN) begin
          // Only the idle instruction loads the status
          stat_d = ctrl_q;
          state_d = ctrl_q[`IDC_CTRL_CPU] ? IDC_IDLE : IDC_RUN;
        end else if (state_q == IDC_IDLE && osc_down) begin
          if (wake_osc) begin
            tstart = 1'b1;
            state_d = IDC_STABLE;
          end
        end else if (state_q == IDC_IDLE && wake_any) begin
          // Wake ends the idle the instruction started
          stat_d = 16'h0000;
          state_d = IDC_RUN;
          resume_d = 1'b1;
        end
      end
      IDC_STABLE: begin
        if (tdone) begin
          // Flow resumes right after the wait
          stat_d = 16'h0000;
          state_d = IDC_RUN;
          resume_d = 1'b1;
        end
      end
      default: begin
        state_d = IDC_RUN;
      end
    endcase
  end

  // Register the sequencing state
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      state_q <= IDC_RUN;
      stat_q <= 16'h0000;
      resume_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stat_q <= stat_d;
      resume_q <= resume_d;
    end
  end

  // Oscillator stabilisation counter
  idc_stable_timer #(
    .CYCLES(STABLE_CYCLES)
  ) i_idc_stable_timer (
    .clk_in(CLK_SYS_IN),
    .rst_in(SYS_RST_IN),
    .start_in(tstart),
    .done_out(tdone)
  );

  // Gate decisions from status, masks and activity
  always_comb begin
    logic mp_req;
    logic em_req;
    logic em_ok;
    mp_req = stat_q[`IDC_CTRL_MP];
    // Memory idle via control only with all masters idled
    em_ok = stat_q[`IDC_CTRL_CPU] & stat_q[`IDC_CTRL_IPORT] & stat_q[`IDC_CTRL_ICACHE]
          & mp_req & mpm_q[`IDC_MP_DMA] & mpm_q[`IDC_MP_HPORT];
    // Either path requests the memory interface idle
    em_req = (stat_q[`IDC_CTRL_EXTMEM] & em_ok)
           | (stat_q[`IDC_CTRL_PERIPHERAL_DOMAIN_IDLE_BIT] & pm_q[`IDC_PM_EXTMEM]);
    gate_d = '0;
    // One disable per status bit
    gate_d.cpu = stat_q[`IDC_CTRL_CPU];
    gate_d.iport = stat_q[`IDC_CTRL_IPORT];
    gate_d.clkgen = stat_q[`IDC_CTRL_CLK];
    // DMA waits out its transfer, once stopped stays stopped
    gate_d.dma = mp_req & mpm_q[`IDC_MP_DMA] & (~DMA_BUSY_IN | gate_q.dma);
    // Host port stops at once
    gate_d.hport = mp_req & mpm_q[`IDC_MP_HPORT];
    // Cache waits for its fill or fetch
    gate_d.icache = stat_q[`IDC_CTRL_ICACHE] & (~ICACHE_BUSY_IN | gate_q.icache);
    // Memory interface waits for the DMA to go quiet
    gate_d.extmem = em_req & (~DMA_BUSY_IN | gate_q.dma | gate_q.extmem);
    // Each masked peripheral stops when idle
    pgate_d = {NUM_PERIPH{stat_q[`IDC_CTRL_PERIPHERAL_DOMAIN_IDLE_BIT]}} & pm_q[NUM_PERIPH-1:0]
            & (~PERIPH_BUSY_IN | pgate_q);
    // Refresh generation lost while memory interface idled
    refr_d = ~gate_d.extmem;
    // PLL and oscillator controls
    pllo_d.pll_en = pll_q[`IDC_PLL_EN];
    pllo_d.pll_rst = pll_q[`IDC_PLL_RST];
    // PLL core powered down in mode three
    pllo_d.pll_pwrdn = pll_q[`IDC_PLL_PWRDN] & stat_q[`IDC_CTRL_CLK];
    pllo_d.osc_pwrdn = (state_d == IDC_IDLE) & stat_d[`IDC_CTRL_CLK]
                     & pll_q[`IDC_PLL_OSCPD];
  end

  // Register the gate outputs
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      gate_q <= '0;
      pgate_q <= '0;
      pllo_q <= '0;
      refr_q <= 1'b1;
    end else begin
      gate_q <= gate_d;
      pgate_q <= pgate_d;
      pllo_q <= pllo_d;
      refr_q <= refr_d;
    end
  end

  // Outputs straight from flip-flops
  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = rdat_q;
  assign GATE_OUT = gate_q;
  assign GATE_PERIPH_OUT = pgate_q;
  assign PLL_OUT = pllo_q;
  assign REFRESH_EN_OUT = refr_q;
  assign RESUME_OUT = resume_q;

endmodule : idc_top

// ### rtl/idc_regs.svh
`ifndef IDC_REGS_SVH
`define IDC_REGS_SVH

// Register byte offsets on the bus
`define IDC_OFS_CTRL 8'h00
`define IDC_OFS_STATUS 8'h04
`define IDC_OFS_MPMASK 8'h08
`define IDC_OFS_PMASK 8'h0C
`define IDC_OFS_PLL 8'h10
`define IDC_OFS_WAKE 8'h14
`define IDC_OFS_GATES 8'h18

// Reset values
`define IDC_RST_CTRL 16'h0000
`define IDC_RST_MPMASK 16'h0000
`define IDC_RST_PMASK 16'h0000
`define IDC_RST_PLL 16'h0000
`define IDC_RST_WAKE 16'h0000

// Writable bits of the idle control, master-port mask and PLL control registers
`define IDC_CTRL_MASK 16'h03FF
`define IDC_MPMASK_MASK 16'h0003
`define IDC_PLL_MASK 16'h000F

// Idle control and idle status bit positions
`define IDC_CTRL_CPU 0
`define IDC_CTRL_MP 1
`define IDC_CTRL_ICACHE 2
`define IDC_CTRL_PERIPHERAL_DOMAIN_IDLE_BIT 3
`define IDC_CTRL_CLK 4
`define IDC_CTRL_EXTMEM 5
`define IDC_CTRL_IPORT 6

// Master-port idle mask bit positions
`define IDC_MP_DMA 0
`define IDC_MP_HPORT 1

// Peripheral idle mask bit that also idles the external memory interface
`define IDC_PM_EXTMEM 0

// PLL control and status bit positions
`define IDC_PLL_EN 0
`define IDC_PLL_PWRDN 1
`define IDC_PLL_RST 2
`define IDC_PLL_OSCPD 3

// Oscillator wakeup enable: NMI bit, external interrupt n at bit n+1
`define IDC_WAKE_NMI 0

// Oscillator stabilisation, in reference clock cycles
`define IDC_OSC_STABLE_CYC 41032

`endif

// ### rtl/idc_pkg.sv
package idc_pkg;

  // Controller sequencing states
  typedef enum logic [1:0] {
    IDC_RUN,
    IDC_IDLE,
    IDC_STABLE
  } idc_state_type;

  // Clock-disable controls of the fixed domains
  typedef struct packed {
    logic iport;
    logic extmem;
    logic clkgen;
    logic icache;
    logic hport;
    logic dma;
    logic cpu;
  } idc_gate_type;

  // Controls toward the PLL and oscillator
  typedef struct packed {
    logic osc_pwrdn;
    logic pll_rst;
    logic pll_pwrdn;
    logic pll_en;
  } idc_pll_type;

endpackage : idc_pkg

// ### rtl/idc_stable_timer.sv
`timescale 1ns/10ps
module idc_stable_timer #(
  parameter int CYCLES = 41032
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  output logic done_out
);
  import idc_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  // Refuse a count the counter cannot hold
  if (CYCLES < 1) begin : g_chk
    $error("idc_stable_timer: CYCLES must be at least 1");
  end

  logic [CW-1:0] cnt_q, cnt_d; // Cycles still to wait
  logic run_q, run_d; // Counting in progress
  logic done_q, done_d; // One-cycle expiry pulse

  // Next count: load on start, count down, pulse at the end
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_d = 1'b0;
    if (start_in) begin
      cnt_d = CW'(CYCLES);
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q == CW'(1)) begin
        run_d = 1'b0;
        done_d = 1'b1;
      end
      cnt_d = cnt_q - CW'(1);
    end
  end

  // Register the counter state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done_q <= done_d;
    end
  end

  assign done_out = done_q;

endmodule : idc_stable_timer

// ### bench/idc_top_monitor.sv
`timescale 1ns/10ps
module idc_top_monitor #(
  parameter int NUM_PERIPH = 14,
  parameter int STABLE_CYCLES = 41032
) (
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  input wire logic IDLE_EXEC_IN,
  input wire logic DMA_BUSY_IN,
  input wire logic [NUM_PERIPH-1:0] PERIPH_BUSY_IN,
  input wire idc_pkg::idc_gate_type GATE_OUT,
  input wire logic [NUM_PERIPH-1:0] GATE_PERIPH_OUT,
  input wire idc_pkg::idc_pll_type PLL_OUT,
  input wire logic REFRESH_EN_OUT,
  input wire logic RESUME_OUT
);
  import idc_pkg::*;
  int cnt_q; // Cycles since oscillator restart
  int cnt_d;
  logic osc_q; // Oscillator power-down one cycle ago
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Next stabilisation count
  always_comb begin
    cnt_d = cnt_q;
    if (osc_q && !PLL_OUT.osc_pwrdn) cnt_d = 1;
    else if (RESUME_OUT) cnt_d = 0;
    else if (cnt_q != 0) cnt_d = cnt_q + 1;
  end
  // Count registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      cnt_q <= 0;
      osc_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      osc_q <= PLL_OUT.osc_pwrdn;
    end
  end
  property p_cpu_rise;
    $rose(GATE_OUT.cpu) |-> $past(IDLE_EXEC_IN, 2);
  endproperty
  a_cpu_rise: assert property (p_cpu_rise)
    else $error("cpu gate rose without idle pulse");
  property p_refresh;
    GATE_OUT.extmem |-> !REFRESH_EN_OUT;
  endproperty
  a_refresh: assert property (p_refresh)
    else $error("refresh on while memory gated");
  property p_dma_wait;
    !GATE_OUT.dma && DMA_BUSY_IN |=> !GATE_OUT.dma;
  endproperty
  a_dma_wait: assert property (p_dma_wait)
    else $error("dma gated during transfer");
  property p_ext_wait;
    !GATE_OUT.extmem && DMA_BUSY_IN |=> !GATE_OUT.extmem;
  endproperty
  a_ext_wait: assert property (p_ext_wait)
    else $error("memory gated during dma transfer");
  property p_periph_wait;
    (GATE_PERIPH_OUT & ~$past(GATE_PERIPH_OUT) & $past(PERIPH_BUSY_IN)) == '0;
  endproperty
  a_periph_wait: assert property (p_periph_wait)
    else $error("busy peripheral gated");
  property p_pll_down;
    $rose(PLL_OUT.pll_pwrdn) |-> $past(IDLE_EXEC_IN, 2);
  endproperty
  a_pll_down: assert property (p_pll_down)
    else $error("pll power-down without idle pulse");
  property p_osc_down;
    $rose(PLL_OUT.osc_pwrdn) |-> $past(IDLE_EXEC_IN);
  endproperty
  a_osc_down: assert property (p_osc_down)
    else $error("oscillator power-down without idle pulse");
  property p_resume;
    RESUME_OUT |-> $past(GATE_OUT.cpu) ##1 !RESUME_OUT;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume pulse malformed");
  property p_stable;
    cnt_q <= STABLE_CYCLES + 6 && (!(RESUME_OUT && cnt_q != 0) || cnt_q >= STABLE_CYCLES);
  endproperty
  a_stable: assert property (p_stable)
    else $error("stabilisation time wrong");
endmodule : idc_top_monitor
bind idc_top idc_top_monitor #(.NUM_PERIPH(NUM_PERIPH), .STABLE_CYCLES(STABLE_CYCLES))
  i_idc_top_monitor (.CLK_SYS_IN, .SYS_RST_IN, .IDLE_EXEC_IN, .DMA_BUSY_IN,
  .PERIPH_BUSY_IN, .GATE_OUT, .GATE_PERIPH_OUT, .PLL_OUT, .REFRESH_EN_OUT, .RESUME_OUT);

// ### bench/idc_top_tb.sv
`timescale 1ns/10ps
module idc_top_tb;
  import idc_pkg::*;
  localparam int STAB = 8; // Short stabilisation
  logic clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, idle = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, ien = 4'h0, eint = 4'h0;
  logic [31:0] dw = 32'h0, dr, rdat;
  logic dma = 1'h0, nmi = 1'h0, ib = 1'h0, res, refr;
  logic [13:0] pbusy = 14'h0, pgate;
  idc_gate_type gate;
  idc_pll_type pll;
  int n_errors = 0;
  int check_count = 0;
  // Clock
  always #5 clk = ~clk;
  idc_top #(.STABLE_CYCLES(STAB)) i_idc_top (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(dw), .WB_ACK_OUT(ack), .WB_DAT_OUT(dr), .IDLE_EXEC_IN(idle),
    .DMA_BUSY_IN(dma), .ICACHE_BUSY_IN(ib), .PERIPH_BUSY_IN(pbusy),
    .CPU_INT_EN_IN(ien), .NMI_IN(nmi), .EXT_INT_IN(eint), .GATE_OUT(gate),
    .GATE_PERIPH_OUT(pgate), .PLL_OUT(pll), .REFRESH_EN_OUT(refr), .RESUME_OUT(res));
  task automatic conclude;
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask : chk
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dw <= d;
    do @(posedge clk); while (ack !== 1'h1);
    rdat = dr;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk("read", e, rdat);
  endtask : rd
  // Idle pulse, returns once gates settled
  task automatic do_idle;
    @(posedge clk);
    idle <= 1'h1;
    @(posedge clk);
    idle <= 1'h0;
    @(posedge clk);
    #1;
  endtask : do_idle
  // Bounded wait for resume
  task automatic wait_res(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (res !== 1'h1 && n < 60);
    chk("resume", 1, res);
    #1;
    chk("gate_off", 0, gate);
  endtask : wait_res
  task automatic nmi_wake;
    int n;
    @(posedge clk);
    nmi <= 1'h1;
    wait_res(n);
    @(posedge clk);
    nmi <= 1'h0;
  endtask : nmi_wake
  task automatic s_reset;
    chk("gate", 0, gate);
    chk("refresh", 1, refr);
    rd(8'h00, 0);
    rd(8'h1C, 0);
  endtask : s_reset
  task automatic s_cpu;
    wb(1'h1, 8'h00, 32'h25);
    repeat (4) @(posedge clk);
    chk("no_gate", 0, gate);
    rd(8'h04, 0);
    ib <= 1'h1;
    do_idle;
    chk("gate", 7'h01, gate);
    chk("refresh", 1, refr);
    rd(8'h04, 32'h25);
    ib <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("icache", 7'h09, gate);
    nmi_wake;
  endtask : s_cpu
  task automatic s_master;
    wb(1'h1, 8'h08, 32'h3);
    wb(1'h1, 8'h00, 32'h3);
    @(posedge clk);
    dma <= 1'h1;
    do_idle;
    chk("hport", 1, gate.hport);
    repeat (5) @(posedge clk);
    chk("dma_wait", 0, gate.dma);
    dma <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("dma", 1, gate.dma);
    nmi_wake;
  endtask : s_master
  task automatic s_periph;
    wb(1'h1, 8'h0C, 32'h3);
    wb(1'h1, 8'h08, 32'h0);
    wb(1'h1, 8'h00, 32'h9);
    @(posedge clk);
    dma <= 1'h1;
    pbusy <= 14'h0002;
    do_idle;
    chk("pgate0", 1, pgate[0]);
    repeat (4) @(posedge clk);
    chk("pgate_wait", 0, pgate[13:1]);
    chk("ext_wait", 0, gate.extmem);
    dma <= 1'h0;
    pbusy <= 14'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("pgate", 1, pgate[13:1]);
    chk("ext", 1, gate.extmem);
    chk("refresh", 0, refr);
    nmi_wake;
  endtask : s_periph
  // Mode two, then mode three
  task automatic s_modes;
    logic [31:0] c [2] = '{32'h3EF, 32'h3FF};
    wb(1'h1, 8'h10, 32'h6);
    wb(1'h1, 8'h0C, 32'h3FFF);
    wb(1'h1, 8'h08, 32'h3);
    for (int i = 0; i < 2; i++) begin
      wb(1'h1, 8'h00, c[i]);
      do_idle;
      chk("gate", i ? 7'h7F : 7'h6F, gate);
      chk("pgate", 14'h3FFF, pgate);
      chk("pll", i ? 4'h6 : 4'h4, pll);
      nmi_wake;
    end
  endtask : s_modes
  task automatic s_osc;
    int n;
    wb(1'h1, 8'h10, 32'hE);
    wb(1'h1, 8'h14, 32'h6);
    wb(1'h1, 8'h00, 32'h3FF);
    ien <= 4'h1;
    do_idle;
    chk("osc_pd", 1, pll.osc_pwrdn);
    @(posedge clk);
    nmi <= 1'h1;
    eint <= 4'h2;
    repeat (20) @(posedge clk);
    chk("osc_hold", 1, pll.osc_pwrdn);
    nmi <= 1'h0;
    eint <= 4'h3;
    wait_res(n);
    chk("stable", 1, n >= STAB);
    @(posedge clk);
    eint <= 4'h0;
  endtask : s_osc
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk); #1;
    s_reset;
    s_cpu;
    s_master;
    s_periph;
    s_modes;
    s_osc;
    conclude;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude;
  end
endmodule : idc_top_tb
